// File: core/bss_hub.sv
`timescale 1ns/1ns
// ==================================================
// Hub round-robin arbiter at half system rate
module bss_hub (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Control
  input  wire logic       i_run,
  input  wire logic [7:0] i_req,
  // Grant
  output logic      [7:0] o_grant,
  output logic      [7:0] o_ack,
  output logic            o_phase
);
  typedef struct packed {
    logic       phase;
    logic [2:0] slot;
    logic [7:0] grant;
    logic [7:0] ack;
  } bss_hub_t;

  bss_hub_t s;
  bss_hub_t next_s;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // Slot advances every second edge, stopped clock restarts at core 0
  always_comb begin
    next_s = s;
    if (!i_run) begin
      next_s.phase = 1'b0;
      next_s.slot  = 3'h0;
    end else begin
      next_s.phase = ~s.phase;
      if (s.phase) begin
        next_s.slot = s.slot + 3'h1;
      end
    end
    next_s.grant = 8'h01 << next_s.slot;
    next_s.ack = i_req & next_s.grant & {8{i_run}};
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s       <= '0;
      s.grant <= 8'h01; // Core 0 owns the first turn, grant never empty
    end else begin
      s <= next_s;
    end
  end

  assign o_grant = s.grant;
  assign o_ack   = s.ack;
  assign o_phase = s.phase;

  property p_rotate;
    (i_run && s.phase) |=> (o_grant == {$past(o_grant[6:0]), $past(o_grant[7])});
  endproperty
  a_rotate: assert property (p_rotate) else $error("hub slot did not rotate");

  property p_half_rate;
    (i_run && $past(i_run)) |-> (o_phase != $past(o_phase));
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("hub phase stuck");

  property p_one_owner;
    $onehot(o_grant) && ((o_ack & ~o_grant) == 8'h00);
  endproperty
  a_one_owner: assert property (p_one_owner) else $error("hub granted two cores");
endmodule

// File: core/bss_pkg.sv
// ==================================================
// Boot and shutdown sequencer constants
package bss_pkg;

  // ==================================================
  // Timing
  localparam int CLK_KHZ         = 25000;
  localparam int POR_DELAY_MS    = 100;
  localparam int RESET_DELAY_MS  = 50;
  localparam int HOST_WAIT_US    = 100;
  localparam int POR_DELAY_CYC   = POR_DELAY_MS * CLK_KHZ;
  localparam int RESET_DELAY_CYC = RESET_DELAY_MS * CLK_KHZ;
  localparam int HOST_WAIT_CYC   = (HOST_WAIT_US * CLK_KHZ + 999) / 1000;
  localparam int CNT_W           = 22;

  // ==================================================
  // Cores, hub and memories
  localparam int          NUM_CORES     = 8;
  localparam int          HUB_DIV       = 2;
  localparam logic [8:0]  COG_LAST_WORD = 9'h1FF;
  localparam logic [8:0]  COG_BOOT_LAST = 9'h1EF;
  localparam logic [7:0]  CORE0_ONLY    = 8'h01;
  localparam int          MAIN_RAM_KB   = 32;
  localparam int          MAIN_ROM_KB   = 32;

  // ==================================================
  // Register map and fields
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam int         CTRL_RESTART = 0;
  localparam int         CTRL_CLK_LO  = 1;
  localparam int         ST_IMG_LO    = 4;
  localparam int         ST_HALTED    = 6;
  localparam int         ST_LOADED    = 7;
  localparam int         ST_CLK_LO    = 8;

  // ==================================================
  // Clock sources and core images
  localparam logic [1:0] CLK_RC   = 2'h0;
  localparam logic [1:0] CLK_PLL  = 2'h1;
  localparam logic [1:0] CLK_XTAL = 2'h2;
  localparam logic [1:0] IMG_NONE   = 2'h0;
  localparam logic [1:0] IMG_LOADER = 2'h1;
  localparam logic [1:0] IMG_INTERP = 2'h2;

  // ==================================================
  // Memory access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;

  // ==================================================
  // Synchroniser lanes and their reset levels
  localparam int         SYNC_W    = 4;
  localparam int         SY_RESET  = 0;
  localparam int         SY_RX     = 1;
  localparam int         SY_BROWN  = 2;
  localparam int         SY_BROWNOUT_DETECT_ENABLE_LOW_L = 3;
  localparam logic [3:0] SYNC_RST  = 4'hA;

  typedef enum logic [3:0] {
    st_por, st_shutdown, st_slow, st_loader, st_host_wait,
    st_host_xfer, st_ee_probe, st_ee_load, st_interp, st_run
  } bss_state_t;

endpackage

// File: core/bss_sync3.sv
`timescale 1ns/1ns
// ==================================================
// Three-stage input synchroniser
module bss_sync3 (
  // Clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst,
  // Lanes
  input  wire logic [bss_pkg::SYNC_W-1:0] i_async,
  output logic      [bss_pkg::SYNC_W-1:0] o_sync
);
  typedef struct packed {
    logic [bss_pkg::SYNC_W-1:0] s1;
    logic [bss_pkg::SYNC_W-1:0] s2;
    logic [bss_pkg::SYNC_W-1:0] s3;
    logic [bss_pkg::SYNC_W-1:0] q;
  } bss_sync_t;

  bss_sync_t s;
  bss_sync_t next_s;

  // Lane follows only once stages two and three agree
  always_comb begin
    next_s    = s;
    next_s.s1 = i_async;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < bss_pkg::SYNC_W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.q[i] = s.s3[i];
      end
    end
  end

  // Register stage
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= {4{bss_pkg::SYNC_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign o_sync = s.q;
endmodule

// File: core/bss_top.sv
`timescale 1ns/1ns
module bss_top #(
  parameter int POR_CYC   = bss_pkg::POR_DELAY_CYC,
  parameter int DELAY_CYC = bss_pkg::RESET_DELAY_CYC
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Supervisory pins
  input  wire logic        i_reset_in_low,
  input  wire logic        i_brownout_detect_enable_low,
  input  wire logic        i_brownout,
  input  wire logic        i_host_serial_rx_pin,
  // Host download engine
  input  wire logic        i_host_done,
  input  wire logic        i_host_loaded,
  input  wire logic        i_host_suspend,
  // EEPROM engine
  input  wire logic        i_ee_ack_valid,
  input  wire logic        i_ee_present,
  input  wire logic        i_ee_done,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Memory access decode
  input  wire logic [15:0] i_mem_addr,
  input  wire logic [1:0]  i_mem_size,
  output logic      [3:0]  o_mem_be,
  output logic             o_mem_rom,
  // Hub
  input  wire logic [7:0]  i_hub_req,
  output logic      [7:0]  o_hub_grant,
  output logic      [7:0]  o_hub_ack,
  output logic             o_hub_phase,
  // Clock and core control
  output logic             o_sysclk_run,
  output logic             o_osc_fast,
  output logic      [1:0]  o_clk_src,
  output logic      [7:0]  o_core_enable,
  output logic      [1:0]  o_core0_image,
  output logic      [8:0]  o_cog_load_addr,
  output logic             o_cog_load_we,
  output logic             o_cog_load_clear,
  output logic             o_pins_input,
  output logic             o_ee_probe
);
  typedef struct packed {
    bss_pkg::bss_state_t          state;
    logic [bss_pkg::CNT_W-1:0]    cnt;
    logic [8:0]                   addr;
    logic                         loaded;
    logic                         halted;
    logic                         restart;
    logic [1:0]                   clk_sel;
    logic                         sysclk_run;
    logic                         osc_fast;
    logic [1:0]                   clk_src;
    logic [7:0]                   core_en;
    logic [1:0]                   img;
    logic                         load_we;
    logic                         load_clr;
    logic                         pins_in;
    logic                         ee_probe;
    logic [3:0]                   be;
    logic                         rom;
    logic [31:0]                  rdata;
  } bss_top_t;

  bss_top_t s;
  bss_top_t next_s;
  logic [bss_pkg::SYNC_W-1:0] sy;
  logic                       rst_high;
  logic                       bo_trip;
  logic                       trigger;
  logic                       exit_ok;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // ==================================================
  // Helpers
  function automatic logic hit(input logic [bss_pkg::CNT_W-1:0] c, input int lim);
    return c >= bss_pkg::CNT_W'(lim - 1);
  endfunction

  function automatic logic [3:0] lanes(input logic [1:0] a, input logic [1:0] sz);
    logic [3:0] r;
    r = 4'hF;
    if (sz == bss_pkg::SZ_BYTE) begin
      r = 4'h1 << a;
    end else if (sz == bss_pkg::SZ_WORD) begin
      r = a[1] ? 4'hC : 4'h3;
    end
    return r;
  endfunction

  // ==================================================
  // Pin synchronisers, all supervisory pins are asynchronous
  bss_sync3 u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_brownout_detect_enable_low, i_brownout,
                  i_host_serial_rx_pin, i_reset_in_low}),
    .o_sync     (sy)
  );

  // Shutdown entry and exit conditions
  assign rst_high = sy[bss_pkg::SY_RESET];
  assign bo_trip  = sy[bss_pkg::SY_BROWN] & ~sy[bss_pkg::SY_BROWNOUT_DETECT_ENABLE_LOW_L];
  assign trigger  = ~rst_high | bo_trip | s.restart;
  assign exit_ok  = rst_high & ~bo_trip;

  // ==================================================
  // Hub arbiter, runs only while the system clock runs
  bss_hub u_hub (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_run      (s.sysclk_run),
    .i_req      (i_hub_req),
    .o_grant    (o_hub_grant),
    .o_ack      (o_hub_ack),
    .o_phase    (o_hub_phase)
  );

  // ==================================================
  // Sequencer
  always_comb begin
    next_s       = s;
    next_s.cnt   = s.cnt + bss_pkg::CNT_W'(1);
    next_s.rdata = 32'h0000_0000;
    next_s.restart = 1'b0;
    case (s.state)
      bss_pkg::st_por: begin
        if (hit(s.cnt, POR_CYC)) begin
          next_s.state = bss_pkg::st_shutdown;
        end
      end
      bss_pkg::st_shutdown: begin
        // Pin low or restart re-arms a halted device
        if (~rst_high || s.restart) begin
          next_s.halted = 1'b0;
        end
        if (exit_ok && !s.halted && !s.restart) begin
          next_s.state  = bss_pkg::st_slow;
          next_s.loaded = 1'b0;
        end
      end
      bss_pkg::st_slow: begin
        if (hit(s.cnt, DELAY_CYC)) begin
          next_s.state = bss_pkg::st_loader;
        end
      end
      bss_pkg::st_loader: begin
        if (s.addr == bss_pkg::COG_LAST_WORD) begin
          next_s.state = bss_pkg::st_host_wait;
        end
      end
      bss_pkg::st_host_wait: begin
        if (!sy[bss_pkg::SY_RX]) begin
          next_s.state = bss_pkg::st_host_xfer;
        end else if (hit(s.cnt, bss_pkg::HOST_WAIT_CYC)) begin
          next_s.state = bss_pkg::st_ee_probe;
        end
      end
      bss_pkg::st_host_xfer: begin
        if (i_host_done) begin
          next_s.loaded = i_host_loaded;
          if (i_host_loaded && !i_host_suspend) begin
            next_s.state = bss_pkg::st_interp;
          end else begin
            next_s.state  = bss_pkg::st_shutdown;
            next_s.halted = 1'b1;
          end
        end
      end
      bss_pkg::st_ee_probe: begin
        if (i_ee_ack_valid) begin
          if (i_ee_present) begin
            next_s.state = bss_pkg::st_ee_load;
          end else begin
            next_s.state  = bss_pkg::st_shutdown;
            next_s.halted = 1'b1;
          end
        end
      end
      bss_pkg::st_ee_load: begin
        if (i_ee_done) begin
          next_s.loaded = 1'b1;
          next_s.state  = bss_pkg::st_interp;
        end
      end
      bss_pkg::st_interp: begin
        if (s.addr == bss_pkg::COG_LAST_WORD) begin
          next_s.state = bss_pkg::st_run;
        end
      end
      default: begin
        next_s.state = bss_pkg::st_run;
      end
    endcase

    if (s.state != bss_pkg::st_por && s.state != bss_pkg::st_shutdown && trigger) begin
      next_s.state  = bss_pkg::st_shutdown;
      next_s.halted = 1'b0;
    end

    // Counters restart on every state change
    if (next_s.state != s.state) begin
      next_s.cnt  = '0;
      next_s.addr = 9'h000;
    end else if (s.load_we) begin
      next_s.addr = s.addr + 9'h001;
    end

    // Register writes
    if (i_wr && i_addr == bss_pkg::REG_CTRL) begin
      next_s.restart = i_wdata[bss_pkg::CTRL_RESTART];
      // Reserved source code is ignored, keeps a legal setting
      if (i_wdata[bss_pkg::CTRL_CLK_LO +: 2] <= bss_pkg::CLK_XTAL) begin
        next_s.clk_sel = i_wdata[bss_pkg::CTRL_CLK_LO +: 2];
      end
    end

    // Register reads, data only in the cycle after the strobe
    if (i_rd && i_addr == bss_pkg::REG_CTRL) begin
      next_s.rdata[bss_pkg::CTRL_CLK_LO +: 2] = s.clk_sel;
    end else if (i_rd && i_addr == bss_pkg::REG_STATUS) begin
      next_s.rdata[3:0]                       = s.state;
      next_s.rdata[bss_pkg::ST_IMG_LO +: 2]   = s.img;
      next_s.rdata[bss_pkg::ST_HALTED]        = s.halted;
      next_s.rdata[bss_pkg::ST_LOADED]        = s.loaded;
      next_s.rdata[bss_pkg::ST_CLK_LO +: 2]   = s.clk_src;
    end

    // Output decode from the coming state keeps outputs aligned with it
    // clock stop and float
    next_s.sysclk_run = next_s.state != bss_pkg::st_shutdown
                      && next_s.state != bss_pkg::st_por;
    next_s.pins_in    = !next_s.sysclk_run;
    next_s.osc_fast   = next_s.sysclk_run && next_s.state != bss_pkg::st_slow;
    next_s.clk_src    = (next_s.state == bss_pkg::st_run) ? next_s.clk_sel
                                                           : bss_pkg::CLK_RC;
    next_s.core_en    = 8'h00;
    next_s.img        = bss_pkg::IMG_NONE;
    next_s.load_we    = 1'b0;
    case (next_s.state)
      bss_pkg::st_loader: begin
        next_s.img     = bss_pkg::IMG_LOADER;
        next_s.load_we = 1'b1;
      end
      bss_pkg::st_host_wait, bss_pkg::st_host_xfer,
      bss_pkg::st_ee_probe, bss_pkg::st_ee_load: begin
        next_s.img     = bss_pkg::IMG_LOADER;
        next_s.core_en = bss_pkg::CORE0_ONLY;
      end
      bss_pkg::st_interp: begin
        next_s.img     = bss_pkg::IMG_INTERP;
        next_s.load_we = 1'b1;
      end
      bss_pkg::st_run: begin
        next_s.img     = bss_pkg::IMG_INTERP;
        next_s.core_en = bss_pkg::CORE0_ONLY;
      end
      default: begin
        next_s.img = bss_pkg::IMG_NONE;
      end
    endcase
    // local words above boot image cleared
    next_s.load_clr = next_s.load_we && next_s.addr > bss_pkg::COG_BOOT_LAST;
    next_s.ee_probe = next_s.state == bss_pkg::st_ee_probe
                    && s.state != bss_pkg::st_ee_probe;
    next_s.be  = lanes(i_mem_addr[1:0], i_mem_size);
    next_s.rom = i_mem_addr[15];
  end

  // ==================================================
  // State register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s         <= '0;
      s.state   <= bss_pkg::st_por;
      s.pins_in <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign o_rdata          = s.rdata;
  assign o_mem_be         = s.be;
  assign o_mem_rom        = s.rom;
  assign o_sysclk_run     = s.sysclk_run;
  assign o_osc_fast       = s.osc_fast;
  assign o_clk_src        = s.clk_src;
  assign o_core_enable    = s.core_en;
  assign o_core0_image    = s.img;
  assign o_cog_load_addr  = s.addr;
  assign o_cog_load_we    = s.load_we;
  assign o_cog_load_clear = s.load_clr;
  assign o_pins_input     = s.pins_in;
  assign o_ee_probe       = s.ee_probe;

  // ==================================================
  // Checks
  sequence s_leave_slow;
    (s.state == bss_pkg::st_slow) ##1 (s.state == bss_pkg::st_loader);
  endsequence
  sequence s_probe_miss;
    (s.state == bss_pkg::st_ee_probe && i_ee_ack_valid && !i_ee_present && !trigger);
  endsequence

  property p_slow_first;
    (s.state == bss_pkg::st_slow) |-> (!o_osc_fast && o_sysclk_run && o_core_enable == 8'h00);
  endproperty
  a_slow_first: assert property (p_slow_first) else $error("slow mode not slow");

  property p_delay;
    s_leave_slow |-> ($past(s.cnt) == bss_pkg::CNT_W'(DELAY_CYC - 1)) && o_osc_fast;
  endproperty
  a_delay: assert property (p_delay) else $error("reset delay length wrong");

  property p_loader;
    (s.state == bss_pkg::st_host_wait) |-> (o_core_enable == 8'h01
      && o_core0_image == bss_pkg::IMG_LOADER);
  endproperty
  a_loader: assert property (p_loader) else $error("loader not on core 0");

  property p_halt;
    s_probe_miss |=> (s.state == bss_pkg::st_shutdown && s.halted && o_pins_input);
  endproperty
  a_halt: assert property (p_halt) else $error("no halt after failed probe");

  property p_shutdown;
    (s.state == bss_pkg::st_shutdown) |-> (!o_sysclk_run && o_pins_input
      && o_core_enable == 8'h00);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown leaves clock on");

  property p_trigger;
    (trigger && s.state != bss_pkg::st_por) |=> (s.state == bss_pkg::st_shutdown);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger missed");

  property p_exit;
    (s.state == bss_pkg::st_shutdown) ##1 (s.state != bss_pkg::st_shutdown)
      |-> $past(exit_ok);
  endproperty
  a_exit: assert property (p_exit) else $error("left shutdown too early");

  property p_run;
    $rose(s.state == bss_pkg::st_interp) |-> s.loaded ##[1:600] (s.state == bss_pkg::st_run
      || s.state == bss_pkg::st_shutdown);
  endproperty
  a_run: assert property (p_run) else $error("interpreter start wrong");

  property p_src;
    (s.state != bss_pkg::st_run) |-> (o_clk_src == bss_pkg::CLK_RC);
  endproperty
  a_src: assert property (p_src) else $error("clock source early");
endmodule

// File: verification/bss_boot_partner.sv
`timescale 1ns/1ns
// ========================================
// Host programmer and serial EEPROM model
module bss_boot_partner (
  // Clock and scenario mode
  input  wire logic       i_core_clk,
  input  wire logic [1:0] i_host_mode,
  input  wire logic       i_ee_mode,
  // Device side
  input  wire logic [1:0] i_core0_image,
  input  wire logic       i_ee_probe,
  // Answers
  output logic            o_rx,
  output logic            o_host_done,
  output logic            o_host_loaded,
  output logic            o_host_suspend,
  output logic            o_ee_ack_valid,
  output logic            o_ee_present,
  output logic            o_ee_done
);
  logic [11:0] hcnt = '0;
  logic [5:0]  ecnt = '0;
  // Loader time and probe age
  always @(posedge i_core_clk) begin
    hcnt <= (i_core0_image == bss_pkg::IMG_LOADER) ? hcnt + 12'h001 : 12'h000;
    ecnt <= i_ee_probe ? 6'h01 : ecnt + {5'h00, ecnt != 6'h00};
  end
  assign o_rx = (i_host_mode != 2'h0 && hcnt != 12'h000) ? hcnt[3] : 1'h1;
  assign o_host_done = i_host_mode != 2'h0 && hcnt > 12'h2BC;
  // Levels outside done mean nothing, so they wander
  assign o_host_loaded = o_host_done | hcnt[0];
  assign o_host_suspend = o_host_done ? i_host_mode == 2'h2 : hcnt[1];
  assign o_ee_ack_valid = ecnt == 6'h03;
  assign o_ee_present = o_ee_ack_valid ? i_ee_mode : ecnt[0];
  assign o_ee_done = i_ee_mode && ecnt > 6'h17;
endmodule

// File: verification/tb.sv
`timescale 1ns/1ns
module tb;
  // ========================================
  // Stimulus and observed signals
  logic        clk = '0, rst = '1, rpin = '1, brownout_detect_enable_low = '1, brown = '0, wr = '0, rd = '0;
  logic        rx, hd, hl, hs, eav, eep, eed, emode = '1, phase, run, fast;
  logic        lwe, lclr, pins, probe, rom;
  logic [7:0]  addr = '0, hreq = '0, grant, ack, cen;
  logic [31:0] wdata = '0, rdata, st;
  logic [15:0] maddr = '0;
  logic [1:0]  msize = '0, hmode = '0, src, img;
  logic [3:0]  be;
  logic [8:0]  laddr;
  int          failures = 0, comparisons = 0, n, probes = 0, p0;

  bss_top #(.POR_CYC(20), .DELAY_CYC(10)) bss_top_inst (
    .i_core_clk(clk), .i_rst(rst), .i_reset_in_low(rpin), .i_brownout_detect_enable_low(brownout_detect_enable_low),
    .i_brownout(brown), .i_host_serial_rx_pin(rx), .i_host_done(hd), .i_host_loaded(hl),
    .i_host_suspend(hs), .i_ee_ack_valid(eav), .i_ee_present(eep), .i_ee_done(eed),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_mem_addr(maddr), .i_mem_size(msize), .o_mem_be(be), .o_mem_rom(rom),
    .i_hub_req(hreq), .o_hub_grant(grant), .o_hub_ack(ack), .o_hub_phase(phase),
    .o_sysclk_run(run), .o_osc_fast(fast), .o_clk_src(src), .o_core_enable(cen),
    .o_core0_image(img), .o_cog_load_addr(laddr), .o_cog_load_we(lwe),
    .o_cog_load_clear(lclr), .o_pins_input(pins), .o_ee_probe(probe));
  bss_boot_partner bss_boot_partner_inst (
    .i_core_clk(clk), .i_host_mode(hmode), .i_ee_mode(emode), .i_core0_image(img),
    .i_ee_probe(probe), .o_rx(rx), .o_host_done(hd), .o_host_loaded(hl),
    .o_host_suspend(hs), .o_ee_ack_valid(eav), .o_ee_present(eep), .o_ee_done(eed));

  // Free-running clock and probe pulse tally
  // 25 MHz within range
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (probe === 1'h1) probes++;

  // ========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 st = rdata;
  endtask
  // Bounded waits on the clock-run flag and core 0 image
  task automatic wrun(input logic e, input int lim);
    n = 0;
    while (run !== e && n < lim) begin
      cyc(1);
      n++;
    end
    chk(run, e);
  endtask
  task automatic wimg(input logic [1:0] e, input int lim);
    n = 0;
    while (img !== e && n < lim) begin
      cyc(1);
      n++;
    end
    chk(img, e);
  endtask
  // Slow start, reset delay, then loader on core 0
  task automatic s_boot;
    wrun(1'h1, 60);
    chk(fast, 1'h0);
    n = 0;
    while (fast !== 1'h1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(n, 10);
    chk(img, bss_pkg::IMG_LOADER);
    chk({cen, lwe, lclr, laddr}, 19'h00400);
    cyc(495);
    chk({cen, lwe, lclr, laddr}, 19'h005EF);
    cyc(1);
    chk({cen, lwe, lclr, laddr}, 19'h007F0);
    cyc(16);
    chk({cen, lwe, lclr, laddr}, 19'h00800);
  endtask
  task automatic s_restart;
    p0 = probes;
    wreg(bss_pkg::REG_CTRL, 32'h0000_0001);
    wrun(1'h0, 6);
    s_boot();
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    cyc(30000);
    failures++;
    complete_run();
  end

  // ========================================
  // Main sequence
  initial begin
    cyc(16);
    chk(pins, 1'h1);
    chk(cen, 8'h00);
    rst <= 1'h0;
    p0 = probes;
    s_boot();
    wimg(bss_pkg::IMG_INTERP, 4000);
    chk(probes - p0, 1);
    cyc(520);
    rreg(bss_pkg::REG_STATUS);
    chk(st[3:0], 4'h9);
    chk(cen, bss_pkg::CORE0_ONLY);
    cyc(1);
    chk(rdata, 32'h0000_0000);
    // Clock source choices, refused code and unmapped place
    for (int k = 0; k < 4; k++) begin
      wreg(bss_pkg::REG_CTRL, 32'(k) << 1);
      rreg(bss_pkg::REG_STATUS);
      chk(st[9:8], (k == 3) ? 2'h2 : 2'(k));
      chk(src, (k == 3) ? 2'h2 : 2'(k));
      rreg(bss_pkg::REG_CTRL);
      chk(st, (k == 3) ? 32'h0000_0004 : 32'(k) << 1);
    end
    rreg(8'h08);
    chk(st, 32'h0000_0000);
    // Hub turns: each core two cycles, in order
    hreq <= 8'h5A;
    cyc(4);
    while (grant === 8'h01) cyc(1);
    n = 0;
    while (grant !== 8'h01 && n < 40) begin
      cyc(1);
      n++;
    end
    for (int c = 0; c < 16; c++) begin
      chk(grant, 8'h01 << (c / 2));
      chk(ack, 8'h5A & (8'h01 << (c / 2)));
      chk(phase, c % 2);
      cyc(1);
    end
    maddr <= 16'h8000;
    msize <= 2'h2;
    cyc(2);
    chk({rom, be}, 5'h1F);
    maddr <= 16'h0003;
    msize <= bss_pkg::SZ_BYTE;
    cyc(2);
    chk({rom, be}, 5'h08);
    maddr <= 16'h0002;
    msize <= bss_pkg::SZ_WORD;
    cyc(2);
    chk({rom, be}, 5'h0C);
    // Brown-out only counts when enabled; pin low holds shutdown
    brown <= 1'h1;
    cyc(10);
    chk(run, 1'h1);
    brownout_detect_enable_low <= 1'h0;
    wrun(1'h0, 8);
    cyc(20);
    chk(run, 1'h0);
    brown <= 1'h0;
    wrun(1'h1, 60);
    rpin <= 1'h0;
    wrun(1'h0, 8);
    cyc(30);
    chk({run, cen, pins}, 10'h001);
    rpin <= 1'h1;
    wrun(1'h1, 60);
    // Nothing answers: halt in shutdown
    emode <= 1'h0;
    s_restart();
    wrun(1'h0, 4000);
    chk({cen, pins}, 9'h001);
    rreg(bss_pkg::REG_STATUS);
    chk(st[6], 1'h1);
    cyc(50);
    chk(run, 1'h0);
    // Host present beats the EEPROM, then a suspended download
    emode <= 1'h1;
    hmode <= 2'h1;
    s_restart();
    wimg(bss_pkg::IMG_INTERP, 4000);
    chk(probes - p0, 0);
    hmode <= 2'h2;
    s_restart();
    wrun(1'h0, 4000);
    chk(img, bss_pkg::IMG_NONE);
    complete_run();
  end
endmodule
